// ### hdl/flash_block_pkg.sv
// constants and types shared by the flash block access logic
// assumes one clock domain; all users write flash_block_pkg::name
package flash_block_pkg;
  localparam int PAGE_W = 3;
  localparam int BLK_W = 2;
  localparam int ADDR_W = 7;
  localparam int NUM_PAGES = 8;
  localparam int NUM_WORDS = 32;
  localparam int PAGE_BITS = 128;
  // width select codes
  localparam logic [1:0] WIDTH_1B = 2'h0;
  localparam logic [1:0] WIDTH_2B = 2'h1;
  localparam logic [1:0] WIDTH_4B = 2'h2;
  // operations, code equals priority level
  localparam logic [2:0] OP_INIT = 3'h0;
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_ERASE = 3'h4;
  localparam logic [2:0] OP_PROGRAM = 3'h5;
  localparam logic [2:0] OP_UNPROTECT = 3'h6;
  localparam logic [2:0] OP_DISCARD = 3'h7;
  // status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_LOCKED = 2'h1;
  localparam logic [1:0] ST_GUARD = 2'h3;
  // APB register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  // interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_GUARD = 1;
  localparam int IRQ_LOCK = 2;
  localparam int IRQ_STALL = 3;
  // reset values, erased word pattern and last page-load count
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic CTRL_SCAN_EN_RESET = 1'b1;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [1:0] LOAD_LAST = 2'h3;
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_BLK, S_MERGE, S_COPY} state_t;
endpackage

// ### hdl/flash_array.sv
// flash array model: words by page and block, one write-lock bit per page
// assumes writes come from flash_block_access on the same clock
`timescale 1ns/100ps
module flash_array (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [2:0] rdPage,
  input wire logic [1:0] rdBlk,
  output logic [31:0] rdWord,
  input wire logic wrEn,
  input wire logic [2:0] wrPage,
  input wire logic [127:0] wrData,
  input wire logic lockWe,
  input wire logic lockVal,
  output logic [7:0] lockBits
);
  typedef struct packed {
    logic [flash_block_pkg::NUM_WORDS-1:0][31:0] mem;
    logic [flash_block_pkg::NUM_PAGES-1:0] lock;
  } arr_t;
  arr_t q;
  arr_t n;

  always_comb begin
    n = q;
    if (wrEn) begin
      for (int b = 0; b < 4; b++) begin
        n.mem[{wrPage, 2'(b)}] = wrData[b*32 +: 32];
      end
    end
    if (lockWe) begin
      n.lock[wrPage] = lockVal;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '{mem: '1, lock: '0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign rdWord = q.mem[{rdPage, rdBlk}];
  assign lockBits = q.lock;
endmodule

// ### hdl/flash_block_access.sv
// flash block access, protection and arbitration with APB registers
// assumes user and scan port inputs are already on mclk
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module flash_block_access (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [1:0] widthSelect,
  input wire logic [6:0] addr,
  input wire logic [31:0] writeDataBus,
  input wire logic [7:0] opReq,
  input wire logic pageHoldGuard,
  input wire logic pageWriteLock,
  input wire logic userPortClaim,
  output logic [31:0] readData,
  output logic [1:0] opStatus,
  output logic opDone,
  output logic busy,
  input wire logic scanReq,
  input wire logic [2:0] scanOp,
  input wire logic [6:0] scanAddr,
  input wire logic [31:0] scanWdata,
  output logic scanStall,
  output logic scanDone
);
  typedef struct packed {
    flash_block_pkg::state_t state;
    logic [2:0] lastOp, bufPage, unprotPage;
    logic [1:0] wsel, blkIdx, loadCnt, status;
    logic [6:0] adr;
    logic [31:0] wdat, blkBuf, rdata, prdata;
    logic scanOwn, bufValid, blkValid, unprotValid, done, scanEn;
    logic [127:0] pageBuf;
    logic [3:0] irqStat, irqMask;
  } st_t;
  st_t q;
  st_t n;

  logic [31:0] rdWord, srcWdat, word;
  logic [7:0] lockBits;
  logic [2:0] arrPage, pick, srcOp, srcPage;
  logic [1:0] arrBlk, srcWsel, srcBlk, finStat;
  logic [127:0] wrData;
  logic [6:0] srcAdr;
  logic [3:0] ev;
  logic wrEn, lockWe, lockVal, userAny, scanGo, go, locked, unprotOk, fin, apbAcc, mapped;

  // ****************************************
  // helpers
  // ****************************************
  // lane position: low address bits dropped by width
  function automatic logic [4:0] laneShift(input logic [1:0] ws, input logic [1:0] a);
    logic [4:0] s;
    s = 5'h00;
    unique case (ws)
      flash_block_pkg::WIDTH_1B: s = {a, 3'h0};
      flash_block_pkg::WIDTH_2B: s = {a[1], 4'h0};
      default: s = 5'h00;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] laneMask(input logic [1:0] ws);
    logic [31:0] m;
    m = 32'hFFFFFFFF;
    unique case (ws)
      flash_block_pkg::WIDTH_1B: m = 32'h000000FF;
      flash_block_pkg::WIDTH_2B: m = 32'h0000FFFF;
      default: m = 32'hFFFFFFFF;
    endcase
    return m;
  endfunction

  function automatic logic [2:0] prioPick(input logic [7:0] r);
    logic [2:0] p;
    p = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (r[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  // ****************************************
  // arbitration
  // ****************************************
  assign busy = (q.state != flash_block_pkg::S_IDLE);
  assign userAny = |opReq;
  assign pick = prioPick(opReq);
  assign scanGo = !userAny && scanReq && !userPortClaim && q.scanEn && !busy;
  assign scanStall = scanReq && !scanGo;
  assign go = !busy && (userAny || scanGo);
  assign srcOp = userAny ? pick : scanOp;
  assign srcWsel = userAny ? widthSelect : flash_block_pkg::WIDTH_4B;
  assign srcAdr = userAny ? addr : scanAddr;
  assign srcWdat = userAny ? writeDataBus : scanWdata;
  assign srcPage = srcAdr[6:4];
  assign srcBlk = srcAdr[3:2];
  assign locked = lockBits[srcPage];
  assign unprotOk = q.unprotValid && (q.unprotPage == srcPage);
  assign arrPage = (q.state == flash_block_pkg::S_LOAD) ? q.adr[6:4] : srcPage;
  assign arrBlk = (q.state == flash_block_pkg::S_LOAD) ? q.loadCnt : srcBlk;
  assign word = (q.bufValid && q.bufPage == srcPage) ? q.pageBuf[{srcBlk, 5'h00} +: 32] : rdWord;
  assign apbAcc = psel && penable;
  assign mapped = (paddr == flash_block_pkg::REG_STATUS) || (paddr == flash_block_pkg::REG_IRQ) ||
                  (paddr == flash_block_pkg::REG_MASK) || (paddr == flash_block_pkg::REG_CTRL);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = q;
    n.done = 1'b0;
    fin = 1'b0;
    finStat = flash_block_pkg::ST_OK;
    wrEn = 1'b0;
    wrData = q.pageBuf;
    lockWe = 1'b0;
    lockVal = pageWriteLock;
    ev = 4'h0;
    unique case (q.state)
      flash_block_pkg::S_IDLE: begin
        if (go) begin
          n.lastOp = srcOp;
          n.wsel = srcWsel;
          n.scanOwn = !userAny;
          unique case (srcOp)
            flash_block_pkg::OP_INIT: begin
              n.bufValid = 1'b0;
              n.blkValid = 1'b0;
              n.unprotValid = 1'b0;
              fin = 1'b1;
            end
            flash_block_pkg::OP_RESET, flash_block_pkg::OP_DISCARD: begin
              n.bufValid = 1'b0;
              n.blkValid = 1'b0;
              fin = 1'b1;
            end
            flash_block_pkg::OP_READ: begin
              n.rdata = (word >> laneShift(srcWsel, srcAdr[1:0])) & laneMask(srcWsel);
              fin = 1'b1;
            end
            flash_block_pkg::OP_WRITE: begin
              if (locked) begin
                fin = 1'b1;
                finStat = flash_block_pkg::ST_LOCKED;
              end else if (pageHoldGuard && q.bufValid && q.bufPage != srcPage) begin
                fin = 1'b1;
                finStat = flash_block_pkg::ST_GUARD;
              end else begin
                n.adr = srcAdr;
                n.wdat = srcWdat & laneMask(srcWsel);
                if (!(q.bufValid && q.bufPage == srcPage)) begin
                  n.state = flash_block_pkg::S_LOAD;
                  n.loadCnt = 2'h0;
                  n.bufValid = 1'b0;
                  n.blkValid = 1'b0;
                end else if (q.blkValid && q.blkIdx == srcBlk) begin
                  n.state = flash_block_pkg::S_MERGE;
                end else begin
                  n.state = flash_block_pkg::S_BLK;
                end
              end
            end
            flash_block_pkg::OP_ERASE: begin
              fin = 1'b1;
              if (locked) begin
                finStat = flash_block_pkg::ST_LOCKED;
              end else begin
                wrEn = 1'b1;
                wrData = {4{flash_block_pkg::ERASED_WORD}};
                if (q.bufPage == srcPage) begin
                  n.bufValid = 1'b0;
                  n.blkValid = 1'b0;
                end
              end
            end
            flash_block_pkg::OP_PROGRAM: begin
              fin = 1'b1;
              if (locked && !unprotOk) begin
                finStat = flash_block_pkg::ST_LOCKED;
              end else begin
                lockWe = 1'b1;
                wrEn = q.bufValid && q.bufPage == srcPage;
                if (unprotOk) begin
                  n.unprotValid = 1'b0;
                end
                if (wrEn) begin
                  n.bufValid = 1'b0;
                  n.blkValid = 1'b0;
                end
              end
            end
            flash_block_pkg::OP_UNPROTECT: begin
              n.unprotValid = 1'b1;
              n.unprotPage = srcPage;
              fin = 1'b1;
            end
          endcase
        end
      end
      flash_block_pkg::S_LOAD: begin
        n.pageBuf[{q.loadCnt, 5'h00} +: 32] = rdWord;
        n.loadCnt = q.loadCnt + 2'h1;
        if (q.loadCnt == flash_block_pkg::LOAD_LAST) begin
          n.bufValid = 1'b1;
          n.bufPage = q.adr[6:4];
          n.state = flash_block_pkg::S_BLK;
        end
      end
      flash_block_pkg::S_BLK: begin
        n.blkBuf = q.pageBuf[{q.adr[3:2], 5'h00} +: 32];
        n.blkIdx = q.adr[3:2];
        n.blkValid = 1'b1;
        n.state = flash_block_pkg::S_MERGE;
      end
      flash_block_pkg::S_MERGE: begin
        n.blkBuf = (q.blkBuf & ~(laneMask(q.wsel) << laneShift(q.wsel, q.adr[1:0]))) |
                   (q.wdat << laneShift(q.wsel, q.adr[1:0]));
        n.state = flash_block_pkg::S_COPY;
      end
      flash_block_pkg::S_COPY: begin
        n.pageBuf[{q.blkIdx, 5'h00} +: 32] = q.blkBuf;
        n.state = flash_block_pkg::S_IDLE;
        fin = 1'b1;
      end
    endcase
    if (fin) begin
      n.status = finStat;
      n.done = 1'b1;
      n.state = flash_block_pkg::S_IDLE;
    end
    ev[flash_block_pkg::IRQ_DONE] = fin;
    ev[flash_block_pkg::IRQ_GUARD] = fin && finStat == flash_block_pkg::ST_GUARD;
    ev[flash_block_pkg::IRQ_LOCK] = fin && finStat == flash_block_pkg::ST_LOCKED;
    ev[flash_block_pkg::IRQ_STALL] = scanReq && userPortClaim;
    // apb slave, read data captured in setup phase
    if (psel && !penable) begin
      unique case (paddr)
        flash_block_pkg::REG_STATUS: n.prdata = {24'h0, q.bufPage, q.bufValid, busy, 1'b0, q.status};
        flash_block_pkg::REG_IRQ: n.prdata = {28'h0, q.irqStat};
        flash_block_pkg::REG_MASK: n.prdata = {28'h0, q.irqMask};
        flash_block_pkg::REG_CTRL: n.prdata = {31'h0, q.scanEn};
        default: n.prdata = 32'h0;
      endcase
    end
    if (apbAcc && pwrite && paddr == flash_block_pkg::REG_MASK) begin
      n.irqMask = pwdata[3:0];
    end
    if (apbAcc && pwrite && paddr == flash_block_pkg::REG_CTRL) begin
      n.scanEn = pwdata[0];
    end
    // read clears, new events win
    if (apbAcc && !pwrite && paddr == flash_block_pkg::REG_IRQ) begin
      n.irqStat = ev;
    end else begin
      n.irqStat = q.irqStat | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '{state: flash_block_pkg::S_IDLE, irqMask: flash_block_pkg::MASK_RESET,
             scanEn: flash_block_pkg::CTRL_SCAN_EN_RESET, default: '0};
    end else if (ce) begin
      q <= n;
    end
  end

  flash_array array (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .rdPage(arrPage),
    .rdBlk(arrBlk),
    .rdWord(rdWord),
    .wrEn(wrEn),
    .wrPage(srcPage),
    .wrData(wrData),
    .lockWe(lockWe),
    .lockVal(lockVal),
    .lockBits(lockBits)
  );

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = apbAcc && !mapped;
  assign irq = |(q.irqStat & q.irqMask);
  assign readData = q.rdata;
  assign opStatus = q.status;
  assign opDone = q.done && !q.scanOwn;
  assign scanDone = q.done && q.scanOwn;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !ce);

  sequence loadPhase;
    (q.state == flash_block_pkg::S_LOAD) [*4];
  endsequence

  chk_two_byte: assert property (q.done && q.lastOp == flash_block_pkg::OP_READ &&
    q.wsel == flash_block_pkg::WIDTH_2B |-> q.rdata[31:16] == 16'h0) else $error("two byte read too wide");
  chk_one_byte: assert property (q.done && q.lastOp == flash_block_pkg::OP_READ &&
    q.wsel == flash_block_pkg::WIDTH_1B |-> q.rdata[31:8] == 24'h0) else $error("one byte read too wide");
  chk_addr_ignore: assert property (go && srcOp == flash_block_pkg::OP_READ && srcWsel[1] |=>
    q.rdata == $past(word)) else $error("word read used low address bits");
  chk_guard_reject: assert property (go && srcOp == flash_block_pkg::OP_WRITE && !locked &&
    pageHoldGuard && q.bufValid && q.bufPage != srcPage |=> q.done && q.status == flash_block_pkg::ST_GUARD &&
    !busy && q.bufPage == $past(q.bufPage)) else $error("guarded write not refused");
  chk_lock_fail: assert property (go && locked && (srcOp == flash_block_pkg::OP_WRITE ||
    srcOp == flash_block_pkg::OP_ERASE) |=> q.status == flash_block_pkg::ST_LOCKED && !busy)
    else $error("locked page not refused");
  chk_lock_set: assert property (go && srcOp == flash_block_pkg::OP_PROGRAM && !locked &&
    pageWriteLock |=> lockBits[$past(srcPage)]) else $error("program did not lock page");
  chk_unlock_store: assert property (go && srcOp == flash_block_pkg::OP_PROGRAM && unprotOk &&
    !pageWriteLock |=> !lockBits[$past(srcPage)] && !q.unprotValid) else $error("unlock not stored");
  chk_scan_hold: assert property (scanReq && userPortClaim |-> scanStall ##1 !q.done || !q.scanOwn ||
    $past(busy)) else $error("scan access not stalled");
  chk_prio_pick: assert property (userAny |-> opReq[pick] &&
    (opReq & ((8'h01 << pick) - 8'h01)) == 8'h00) else $error("priority pick wrong");
  chk_page_load: assert property (go && srcOp == flash_block_pkg::OP_WRITE && !locked &&
    !(q.bufValid && q.bufPage == srcPage) && !(pageHoldGuard && q.bufValid) |=>
    loadPhase ##1 q.state == flash_block_pkg::S_BLK && q.bufValid) else $error("page load sequence wrong");
  chk_blk_reload: assert property (q.state == flash_block_pkg::S_BLK |=>
    q.state == flash_block_pkg::S_MERGE && q.blkBuf == q.pageBuf[{q.blkIdx, 5'h00} +: 32])
    else $error("block buffer not reloaded");
  chk_blk_copy: assert property (q.state == flash_block_pkg::S_MERGE |=>
    q.state == flash_block_pkg::S_COPY ##1 q.done && q.pageBuf[{q.blkIdx, 5'h00} +: 32] == q.blkBuf)
    else $error("page buffer out of step with block buffer");
endmodule

// ### verification/user_fabric_model.sv
// user fabric side model: drives one operation at a time on the user port
// assumes flash_block_access user port on mclk, requests only while busy is low
`timescale 1ns/100ps
module user_fabric_model (
  input wire logic mclk,
  input wire logic busy,
  input wire logic opDone,
  output logic [7:0] opReq,
  output logic [1:0] widthSelect,
  output logic [6:0] addr,
  output logic [31:0] writeDataBus,
  output logic pageHoldGuard,
  output logic pageWriteLock
);
  initial begin
    opReq = 8'h00;
    widthSelect = 2'h0;
    addr = 7'h00;
    writeDataBus = 32'h00000000;
    pageHoldGuard = 1'b0;
    pageWriteLock = 1'b0;
  end
  task automatic op(input logic [7:0] req, input logic [1:0] w, input logic [6:0] a, input logic [31:0] d,
    input logic g, input logic l, output logic ok);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    opReq <= req;
    widthSelect <= w;
    addr <= a;
    pageHoldGuard <= g;
    pageWriteLock <= l;
    // bits above the width tied low
    writeDataBus <= (w == 2'h0) ? {24'h000000, d[7:0]} : (w == 2'h1) ? {16'h0000, d[15:0]} : d;
    @(posedge mclk);
    opReq <= 8'h00;
    addr <= ~a;
    writeDataBus <= ~d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (opDone !== 1'b1 && n < 20);
    ok = (opDone === 1'b1);
  endtask
endmodule

// ### verification/tb_flash_block_access.sv
// self-checking bench for flash_block_access with user, scan and APB sides
// assumes the array sits inside the design and reads back little endian bytes
`timescale 1ns/100ps
module tb_flash_block_access;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, irq, userPortClaim, busy, opDone;
  logic scanReq, scanStall, scanDone, ok, er, ce, pageHoldGuard, pageWriteLock;
  logic [7:0] paddr, opReq;
  logic [31:0] pwdata, prdata, writeDataBus, readData, scanWdata, rd, x, d;
  logic [1:0] widthSelect, opStatus, w;
  logic [6:0] addr, scanAddr, a;
  logic [2:0] scanOp;
  logic [7:0] mem [0:127];
  int errors = 0;
  int total_checks = 0;
  flash_block_access i_flash_block_access (.mclk(mclk), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .widthSelect(widthSelect), .addr(addr), .writeDataBus(writeDataBus),
    .opReq(opReq), .pageHoldGuard(pageHoldGuard), .pageWriteLock(pageWriteLock),
    .userPortClaim(userPortClaim), .readData(readData), .opStatus(opStatus), .opDone(opDone), .busy(busy),
    .scanReq(scanReq), .scanOp(scanOp), .scanAddr(scanAddr), .scanWdata(scanWdata), .scanStall(scanStall),
    .scanDone(scanDone));
  user_fabric_model i_user_fabric_model (.mclk(mclk), .busy(busy), .opDone(opDone), .opReq(opReq),
    .widthSelect(widthSelect), .addr(addr), .writeDataBus(writeDataBus), .pageHoldGuard(pageHoldGuard),
    .pageWriteLock(pageWriteLock));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int nbytes(input logic [1:0] wd);
    return (wd == 2'h0) ? 1 : (wd == 2'h1) ? 2 : 4;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [1:0] wd, input logic [6:0] ad);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < nbytes(wd); i++) r[8*i +: 8] = mem[(ad & ~7'(nbytes(wd) - 1)) + i];
    return r;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic uop(input int code, input logic [1:0] wd, input logic [6:0] ad, input logic [31:0] dt,
    input logic g, input logic l, input logic [1:0] st);
    i_user_fabric_model.op(8'h01 << code, wd, ad, dt, g, l, ok);
    chk({31'h0, ok}, 32'h1, "no completion");
    chk({30'h0, opStatus}, {30'h0, st}, "status");
    chk({31'h0, busy}, 32'h0, "busy after done");
    if (code == 3 && st == flash_block_pkg::ST_OK)
      for (int i = 0; i < nbytes(wd); i++) mem[(ad & ~7'(nbytes(wd) - 1)) + i] = dt[8*i +: 8];
    if (code == 2) chk(readData, exp_rd(wd, ad), "read data");
  endtask
  // ****************************************
  // clock, reset, sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, userPortClaim, scanReq} = 5'h00;
    {paddr, pwdata, scanOp, scanAddr, scanWdata} = '0;
    for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
    x = 32'h962F;
    ce = 1'b1;
    reset = 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, flash_block_pkg::REG_MASK, 32'h0, rd, er);
    chk(rd, 32'h0, "mask reset");
    apb(1'b0, flash_block_pkg::REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h1, "ctrl reset");
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped");
    apb(1'b1, flash_block_pkg::REG_MASK, 32'h7, rd, er);
    for (int k = 0; k < 12; k++) begin
      x = lfsr(x);
      d = lfsr(x);
      w = x[5:4];
      a = {3'h1, x[3:0]};
      uop(3, w, a, d, 1'b0, 1'b0, flash_block_pkg::ST_OK);
      uop(2, x[7:6], {3'h1, x[11:8]}, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
      uop(2, 2'h2, a, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    end
    i_user_fabric_model.op(8'h0C, 2'h2, 7'h14, ~x, 1'b0, 1'b0, ok);
    chk(readData, exp_rd(2'h2, 7'h14), "read first");
    uop(2, 2'h2, 7'h14, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    uop(5, 2'h2, 7'h10, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    uop(3, 2'h2, 7'h24, x, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    uop(3, 2'h2, 7'h30, d, 1'b1, 1'b0, flash_block_pkg::ST_GUARD);
    uop(2, 2'h2, 7'h24, 32'h0, 1'b1, 1'b0, flash_block_pkg::ST_OK);
    uop(7, 2'h2, 7'h20, 32'h0, 1'b1, 1'b0, flash_block_pkg::ST_OK);
    for (int i = 32; i < 48; i++) mem[i] = 8'hFF;
    uop(3, 2'h0, 7'h31, d, 1'b1, 1'b0, flash_block_pkg::ST_OK);
    uop(5, 2'h2, 7'h30, 32'h0, 1'b0, 1'b1, flash_block_pkg::ST_OK);
    uop(3, 2'h2, 7'h30, x, 1'b0, 1'b0, flash_block_pkg::ST_LOCKED);
    uop(4, 2'h2, 7'h30, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_LOCKED);
    uop(5, 2'h2, 7'h30, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_LOCKED);
    uop(6, 2'h2, 7'h30, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    uop(5, 2'h2, 7'h30, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    uop(3, 2'h1, 7'h32, x, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    uop(2, 2'h2, 7'h30, 32'h0, 1'b0, 1'b0, flash_block_pkg::ST_OK);
    #1;
    chk({31'h0, irq}, 32'h1, "irq set");
    apb(1'b0, flash_block_pkg::REG_IRQ, 32'h0, rd, er);
    chk(rd, 32'h7, "irq bits");
    #1;
    chk({31'h0, irq}, 32'h0, "irq cleared");
    @(posedge mclk);
    ce <= 1'b0;
    i_user_fabric_model.op(8'h04, 2'h2, 7'h30, 32'h0, 1'b0, 1'b0, ok);
    chk({31'h0, ok}, 32'h0, "op taken while frozen");
    ce <= 1'b1;
    @(posedge mclk);
    userPortClaim <= 1'b1;
    scanReq <= 1'b1;
    scanOp <= flash_block_pkg::OP_READ;
    scanAddr <= 7'h30;
    scanWdata <= lfsr(x);
    repeat (6) @(posedge mclk);
    #1;
    chk({30'h0, scanStall, scanDone}, 32'h2, "scan held");
    @(posedge mclk);
    userPortClaim <= 1'b0;
    for (int n = 0; n < 20 && scanDone !== 1'b1; n++) @(posedge mclk) #1;
    chk({31'h0, scanDone}, 32'h1, "scan resumed");
    chk(readData, exp_rd(2'h2, 7'h30), "scan read data");
    @(posedge mclk);
    scanReq <= 1'b0;
    report_and_stop();
  end
endmodule
